/* tap_defines.svh */
// Constants of the boundary-scan test port: register lengths, cell positions, fixed values and times.
`ifndef TAP_DEFINES_SVH
`define TAP_DEFINES_SVH

// ----------------------------------------------------------------
// scan register lengths
// ----------------------------------------------------------------
`define IR_LEN 3
`define ID_LEN 32
`define BSR_LEN 107

// ----------------------------------------------------------------
// cell and field positions
// ----------------------------------------------------------------
`define BSR_INTERNAL_CELL 47
`define ID_START_BIT 0
`define ID_MFR_LSB 1
`define ID_PART_LSB 12
`define ID_REV_LSB 29

// ----------------------------------------------------------------
// fixed values
// ----------------------------------------------------------------
`define IR_CAPTURE_VAL 3'h1
`define BYPASS_CAPTURE_VAL 1'h0
`define ID_START_VAL 1'h1
// identity defaults: arbitrary values
`define ID_REV_DEFAULT 3'h5
`define ID_PART_DEFAULT 17'h0A5A5
`define ID_MFR_DEFAULT 11'h2B3

// ----------------------------------------------------------------
// times and buffering
// ----------------------------------------------------------------
`define CORE_CLK_NS 40
`define TCK_MIN_PERIOD_NS 50
`define TCK_MIN_PHASE_NS 20
`define TDO_VALID_NS 10
`define FIFO_DEPTH 16
`define FIFO_WIDTH 2

`endif

/* tap_pkg.sv */
// Types shared by the test port: controller states and instruction codes.
package tap_pkg;

   // ----------------------------------------------------------------
   // controller states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [15:0] {
      TAP_RESET     = 16'h0001,
      TAP_IDLE      = 16'h0002,
      TAP_SEL_DR    = 16'h0004,
      TAP_CAP_DR    = 16'h0008,
      TAP_SHIFT_DR  = 16'h0010,
      TAP_EXIT1_DR  = 16'h0020,
      TAP_PAUSE_DR  = 16'h0040,
      TAP_EXIT2_DR  = 16'h0080,
      TAP_UPD_DR    = 16'h0100,
      TAP_SEL_IR    = 16'h0200,
      TAP_CAP_IR    = 16'h0400,
      TAP_SHIFT_IR  = 16'h0800,
      TAP_EXIT1_IR  = 16'h1000,
      TAP_PAUSE_IR  = 16'h2000,
      TAP_EXIT2_IR  = 16'h4000,
      TAP_UPD_IR    = 16'h8000
   } tap_state_t;

   // ----------------------------------------------------------------
   // instruction codes; 3'h3, 3'h5 and 3'h6 are reserved
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      INS_EXTEST       = 3'h0,
      INS_IDCODE       = 3'h1,
      INS_SAMPLE_FLOAT = 3'h2,
      INS_SAMPLE       = 3'h4,
      INS_BYPASS       = 3'h7
   } instr_t;

endpackage

/* scan_fifo.sv */
// Small FIFO with registered read data, used for the serial output stream.
`timescale 1ns/1ps
`include "tap_defines.svh"

module scan_fifo #(
   parameter int WIDTH = `FIFO_WIDTH,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input wire logic core_clk,             // block clock
   input wire logic rst,                  // synchronous reset, high
   input wire logic in_valid,             // write request
   output logic in_ready,                 // space available
   input wire logic [WIDTH-1:0] in_data,  // write data
   output logic out_valid,                // data available
   input wire logic out_ready,            // consumer takes the head
   output logic [WIDTH-1:0] out_data      // head of queue, registered
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
      $error("scan_fifo: DEPTH must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic [WIDTH-1:0] data;
   } fifo_state_t;

   fifo_state_t s_q;
   fifo_state_t s_d;
   logic push;
   logic pop;

   assign in_ready = s_q.count != FULL;
   assign out_valid = s_q.count != '0;
   assign out_data = s_q.data;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wptr] = in_data;
         s_d.wptr = s_q.wptr + AW'(1);
      end
      if (pop) begin
         s_d.rptr = s_q.rptr + AW'(1);
      end
      s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
      // bypass keeps the head register right when an empty queue is written
      if (push && s_q.wptr == s_d.rptr) begin
         s_d.data = in_data;
      end else begin
         s_d.data = s_q.mem[s_d.rptr];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   fifo_count_a: assert property (@(posedge core_clk) disable iff (rst)
      s_q.count <= FULL)
      else $error("fifo count beyond depth");
endmodule

/* sram_tap.sv */
// Boundary-scan test access port of the burst memory, oversampling the test clock on core_clk.
`timescale 1ns/1ps
`include "tap_defines.svh"

module sram_tap
   import tap_pkg::*;
#(
   parameter int BSR_LEN = `BSR_LEN,
   parameter int INTERNAL_CELL = `BSR_INTERNAL_CELL,
   parameter int FIFO_DEPTH = `FIFO_DEPTH,
   parameter logic [2:0] ID_REVISION = `ID_REV_DEFAULT,    // arbitrary value
   parameter logic [16:0] ID_PART = `ID_PART_DEFAULT,      // arbitrary value
   parameter logic [10:0] ID_MANUFACTURER = `ID_MFR_DEFAULT // arbitrary value
) (
   input wire logic core_clk,              // block clock, 25 MHz
   input wire logic rst,                   // synchronous reset, high
   input wire logic tck,                   // test clock pin
   input wire logic tms,                   // mode select pin
   input wire logic tdi,                   // serial data in pin
   input wire logic tms_float,             // mode select pin undriven
   input wire logic tdi_float,             // data in pin undriven
   input wire logic [BSR_LEN-1:0] pad_in,  // pad levels seen by the chain
   output logic tdo,                       // serial data out
   output logic tdo_oe,                    // serial out driven
   output logic dq_float                   // data outputs forced to float
);
   // ----------------------------------------------------------------
   // derived constants and parameter checks
   // ----------------------------------------------------------------
   localparam int TDO_VALID_RAW = `TDO_VALID_NS / `CORE_CLK_NS;
   localparam int TDO_VALID_CYC = (TDO_VALID_RAW < 1) ? 1 : TDO_VALID_RAW;
   localparam int TCK_MIN_CYC = (`TCK_MIN_PERIOD_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS;
   localparam logic [`ID_LEN-1:0] ID_VALUE = {ID_REVISION, ID_PART, ID_MANUFACTURER, `ID_START_VAL};

   if (BSR_LEN < 2 || INTERNAL_CELL < 0 || INTERNAL_CELL >= BSR_LEN) begin : g_bad_chain
      $error("sram_tap: internal cell must lie inside the chain");
   end
   if ($bits(ID_VALUE) != `ID_LEN) begin : g_bad_id
      $error("sram_tap: id fields must fill the id register");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] tck_s;
      logic [1:0] tms_s;
      logic [1:0] tdi_s;
      logic [1:0] tmsf_s;
      logic [1:0] tdif_s;
      logic [BSR_LEN-1:0] pad_s1;
      logic [BSR_LEN-1:0] pad_s2;
      tap_state_t tap;
      instr_t ir;
      logic [`IR_LEN-1:0] ir_sh;
      logic byp;
      logic [`ID_LEN-1:0] id_sh;
      logic [BSR_LEN-1:0] bsr_sh;
      logic dq_float;
      logic tdo;
      logic tdo_oe;
   } tap_regs_t;

   tap_regs_t s_q;
   tap_regs_t s_d;

   logic rise;
   logic fall;
   logic take_rise;
   logic tms_eff;
   logic tdi_eff;
   logic sel_id;
   logic sel_bsr;
   logic [BSR_LEN-1:0] capt;
   logic [1:0] push_data;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [1:0] fifo_out_data;

   // ----------------------------------------------------------------
   // capture vector: pads plus the internal float cell
   // ----------------------------------------------------------------
   for (genvar i = 0; i < BSR_LEN; i++) begin : g_capt
      if (i == INTERNAL_CELL) begin : g_int
         assign capt[i] = s_q.dq_float;
      end else begin : g_pad
         assign capt[i] = s_q.pad_s2[i];
      end
   end

   // ----------------------------------------------------------------
   // controller next state
   // ----------------------------------------------------------------
   function automatic tap_state_t next_tap(input tap_state_t st, input logic m);
      tap_state_t nx;
      nx = TAP_RESET;
      case (st)
         TAP_RESET: nx = m ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: nx = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: nx = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: nx = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: nx = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: nx = m ? TAP_UPD_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: nx = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: nx = m ? TAP_UPD_DR : TAP_SHIFT_DR;
         TAP_UPD_DR: nx = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: nx = m ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: nx = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: nx = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: nx = m ? TAP_UPD_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: nx = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: nx = m ? TAP_UPD_IR : TAP_SHIFT_IR;
         TAP_UPD_IR: nx = m ? TAP_SEL_DR : TAP_IDLE;
         default: nx = TAP_RESET;
      endcase
      return nx;
   endfunction

   // ----------------------------------------------------------------
   // edges and effective inputs
   // ----------------------------------------------------------------
   // no clock enable: edges come from the twice-synchronised test clock
   assign rise = s_q.tck_s[1] & ~s_q.tck_s[2];
   assign fall = ~s_q.tck_s[1] & s_q.tck_s[2];
   // a full queue drops the edge; cannot happen since every fall drains one
   assign take_rise = rise & fifo_in_ready;
   assign tms_eff = s_q.tms_s[1] | s_q.tmsf_s[1];
   assign tdi_eff = s_q.tdi_s[1] | s_q.tdif_s[1];
   // reserved codes fall through to bypass
   assign sel_id = s_q.ir == INS_IDCODE;
   assign sel_bsr = s_q.ir == INS_EXTEST || s_q.ir == INS_SAMPLE_FLOAT || s_q.ir == INS_SAMPLE;

   // ----------------------------------------------------------------
   // main update
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      push_data = '0;
      s_d.tck_s = {s_q.tck_s[1:0], tck};
      s_d.tms_s = {s_q.tms_s[0], tms};
      s_d.tdi_s = {s_q.tdi_s[0], tdi};
      s_d.tmsf_s = {s_q.tmsf_s[0], tms_float};
      s_d.tdif_s = {s_q.tdif_s[0], tdi_float};
      s_d.pad_s1 = pad_in;
      s_d.pad_s2 = s_q.pad_s1;

      if (take_rise) begin
         s_d.tap = next_tap(s_q.tap, tms_eff);
         case (s_q.tap)
            TAP_CAP_IR: begin
               s_d.ir_sh = `IR_CAPTURE_VAL;
            end
            TAP_SHIFT_IR: begin
               s_d.ir_sh = {tdi_eff, s_q.ir_sh[`IR_LEN-1:1]};
            end
            TAP_UPD_IR: begin
               s_d.ir = instr_t'(s_q.ir_sh);
            end
            TAP_CAP_DR: begin
               if (sel_id) begin
                  s_d.id_sh = ID_VALUE;
               end else if (sel_bsr) begin
                  s_d.bsr_sh = capt;
               end else begin
                  s_d.byp = `BYPASS_CAPTURE_VAL;
               end
            end
            TAP_SHIFT_DR: begin
               if (sel_id) begin
                  s_d.id_sh = {tdi_eff, s_q.id_sh[`ID_LEN-1:1]};
               end else if (sel_bsr) begin
                  s_d.bsr_sh = {tdi_eff, s_q.bsr_sh[BSR_LEN-1:1]};
               end else begin
                  s_d.byp = tdi_eff;
               end
            end
            default: begin
            end
         endcase
      end

      if (s_d.tap == TAP_RESET) begin
         s_d.ir = INS_IDCODE;
      end
      // float only for EXTEST and the float-sample code
      s_d.dq_float = s_d.ir == INS_EXTEST || s_d.ir == INS_SAMPLE_FLOAT;

      // queue the bit that must appear on the next falling edge; only scan cells reach it
      push_data[1] = s_d.tap == TAP_SHIFT_DR || s_d.tap == TAP_SHIFT_IR;
      if (s_d.tap == TAP_SHIFT_IR) begin
         push_data[0] = s_d.ir_sh[0];
      end else if (sel_id) begin
         push_data[0] = s_d.id_sh[0];
      end else if (sel_bsr) begin
         push_data[0] = s_d.bsr_sh[0];
      end else begin
         push_data[0] = s_d.byp;
      end

      if (fall && fifo_out_valid) begin
         s_d.tdo = fifo_out_data[0];
         s_d.tdo_oe = fifo_out_data[1];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.tap <= TAP_RESET;
         s_q.ir <= INS_IDCODE;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // serial output queue
   // ----------------------------------------------------------------
   scan_fifo #(
      .WIDTH(`FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(rise),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(fifo_out_valid),
      .out_ready(fall),
      .out_data(fifo_out_data)
   );

   assign tdo = s_q.tdo;
   assign tdo_oe = s_q.tdo_oe;
   assign dq_float = s_q.dq_float;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   reset_state_a: assert property (@(posedge core_clk)
      rst |=> s_q.tap == TAP_RESET && s_q.ir == INS_IDCODE && !s_q.dq_float)
      else $error("controller not in reset state after reset");

   state_on_rise_a: assert property (@(posedge core_clk) disable iff (rst)
      s_q.tap != $past(s_q.tap) |-> $past(take_rise))
      else $error("controller moved without a rising test clock");

   ir_update_only_a: assert property (@(posedge core_clk) disable iff (rst)
      s_q.ir != $past(s_q.ir) |-> $past(s_q.tap) == TAP_UPD_IR || s_q.tap == TAP_RESET)
      else $error("instruction changed outside update or reset");

   reset_loads_id_a: assert property (@(posedge core_clk) disable iff (rst)
      take_rise && s_q.tap == TAP_SEL_IR && tms_eff |=> s_q.ir == INS_IDCODE ##1 !s_q.dq_float)
      else $error("reset state did not restore id instruction");

   extest_float_a: assert property (@(posedge core_clk) disable iff (rst)
      take_rise && s_q.tap == TAP_UPD_IR && s_q.ir_sh == INS_EXTEST |=> ##1 s_q.dq_float)
      else $error("all-zero code did not float outputs");

   samplez_float_a: assert property (@(posedge core_clk) disable iff (rst)
      take_rise && s_q.tap == TAP_UPD_IR && s_q.ir_sh == INS_SAMPLE_FLOAT |=> ##1 s_q.dq_float)
      else $error("float-sample code did not float outputs");

   sample_drives_a: assert property (@(posedge core_clk) disable iff (rst)
      s_q.ir == INS_SAMPLE |-> !s_q.dq_float)
      else $error("sample code floated outputs");

   bypass_capture_a: assert property (@(posedge core_clk) disable iff (rst)
      take_rise && s_q.tap == TAP_CAP_DR && !sel_id && !sel_bsr |=> s_q.byp == 1'b0)
      else $error("bypass not cleared on capture");

   id_start_bit_a: assert property (@(posedge core_clk) disable iff (rst)
      take_rise && s_q.tap == TAP_CAP_DR && sel_id
      |=> s_q.id_sh[`ID_START_BIT] && s_q.id_sh[`ID_LEN-1:`ID_REV_LSB] == ID_REVISION)
      else $error("id register captured wrong start bit or revision");

   id_shift_in_a: assert property (@(posedge core_clk) disable iff (rst)
      take_rise && s_q.tap == TAP_SHIFT_DR && sel_id |=> s_q.id_sh[`ID_LEN-1] == $past(tdi_eff))
      else $error("data-in did not enter the id register");

   ir_capture_a: assert property (@(posedge core_clk) disable iff (rst)
      take_rise && s_q.tap == TAP_CAP_IR |=> s_q.ir_sh == `IR_CAPTURE_VAL)
      else $error("instruction capture value wrong");

   internal_cell_a: assert property (@(posedge core_clk) disable iff (rst)
      take_rise && s_q.tap == TAP_CAP_DR && sel_bsr |=> s_q.bsr_sh[INTERNAL_CELL] == $past(s_q.dq_float))
      else $error("internal chain cell captured wrong value");

   tdo_after_fall_a: assert property (@(posedge core_clk) disable iff (rst)
      fall && fifo_out_valid |-> ##TDO_VALID_CYC s_q.tdo == $past(fifo_out_data[0], TDO_VALID_CYC))
      else $error("serial output not updated after falling test clock");

   tdo_only_fall_a: assert property (@(posedge core_clk) disable iff (rst)
      $changed(s_q.tdo_oe) |-> $past(fall))
      else $error("serial output enable changed without falling edge");

   float_reads_one_a: assert property (@(posedge core_clk) disable iff (rst)
      s_q.tmsf_s[1] && s_q.tdif_s[1] |-> tms_eff && tdi_eff)
      else $error("undriven input not read as one");

   oe_only_shift_a: assert property (@(posedge core_clk) disable iff (rst)
      s_q.tdo_oe |-> s_q.tap inside {TAP_SHIFT_DR, TAP_SHIFT_IR, TAP_EXIT1_DR, TAP_EXIT1_IR})
      else $error("serial output enabled outside shift");

   bypass_shift_a: assert property (@(posedge core_clk) disable iff (rst)
      take_rise && s_q.tap == TAP_SHIFT_DR && !sel_id && !sel_bsr |=> s_q.byp == $past(tdi_eff))
      else $error("bypass did not take data-in");

   chain_shift_a: assert property (@(posedge core_clk) disable iff (rst)
      take_rise && s_q.tap == TAP_SHIFT_DR && sel_bsr |=> s_q.bsr_sh[BSR_LEN-1] == $past(tdi_eff))
      else $error("data-in did not enter the chain");

   ir_shift_a: assert property (@(posedge core_clk) disable iff (rst)
      take_rise && s_q.tap == TAP_SHIFT_IR |=> s_q.ir_sh[`IR_LEN-1] == $past(tdi_eff))
      else $error("data-in did not enter the instruction shifter");

   ir_held_dr_a: assert property (@(posedge core_clk) disable iff (rst)
      s_q.tap inside {TAP_CAP_DR, TAP_SHIFT_DR} |=> s_q.ir == $past(s_q.ir))
      else $error("instruction changed during data scan");

   tdo_oe_fall_a: assert property (@(posedge core_clk) disable iff (rst)
      fall && fifo_out_valid |=> s_q.tdo_oe == $past(fifo_out_data[1]))
      else $error("serial output enable not updated after falling test clock");

   if (TCK_MIN_CYC < 1) begin : g_bad_clk
      $error("sram_tap: core clock too slow for test clock");
   end
endmodule

/* tap_host.sv */
// Board test controller model that drives the test port pins from the block clock.
`timescale 1ns/1ps

module tap_host (
   input wire logic core_clk,  // block clock
   input wire logic tdo,       // serial data from the port
   output logic tck,           // test clock pin
   output logic tms,           // mode select pin
   output logic tdi,           // serial data pin
   output logic tms_float,     // mode select released
   output logic tdi_float      // serial data released
);
   // ----------------------------------------------------------------
   // idle levels
   // ----------------------------------------------------------------
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      tms_float = 1'b0;
      tdi_float = 1'b0;
   end

   // ----------------------------------------------------------------
   // one test clock period: 160 ns low, 160 ns high
   // ----------------------------------------------------------------
   // a released pin shows the opposite level, so a wrong default cannot pass by luck
   task automatic clk_bit(input logic m, input logic d, output logic early, output logic late);
      tms <= tms_float ? 1'b0 : m;
      tdi <= tdi_float ? 1'b0 : d;
      repeat (4) @(posedge core_clk);
      tck <= 1'b1;
      @(negedge core_clk);
      early = tdo;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      late = tdo;
      @(posedge core_clk);
      tck <= 1'b0;
   endtask
endmodule

/* tb_sram_tap.sv */
// Self-checking testbench of the boundary-scan test port.
`timescale 1ns/1ps
`include "tap_defines.svh"

module tb_sram_tap
   import tap_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic tck, tms, tdi, tms_float, tdi_float;
   logic [`BSR_LEN-1:0] pad_in = '0;
   logic tdo, tdo_oe, dq_float;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   localparam logic [31:0] ID_EXP = {`ID_REV_DEFAULT, `ID_PART_DEFAULT, `ID_MFR_DEFAULT, `ID_START_VAL};

   always #20 core_clk = ~core_clk;

   sram_tap DUT (.core_clk(core_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tms_float(tms_float),
      .tdi_float(tdi_float), .pad_in(pad_in), .tdo(tdo), .tdo_oe(tdo_oe), .dq_float(dq_float));
   tap_host host (.core_clk(core_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .tms_float(tms_float),
      .tdi_float(tdi_float));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // tdo must not move while tck is high
   task automatic bitx(input logic m, input logic d, output logic o);
      logic e;
      host.clk_bit(m, d, e, o);
      check(e, o);
   endtask

   task automatic move(input logic [7:0] path, input int n);
      logic o;
      for (int i = 0; i < n; i++) begin
         bitx(path[i], 1'b1, o);
      end
   endtask

   task automatic shift(input int n, input logic [127:0] din, output logic [127:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         bitx(i == n - 1, din[i], dout[i]);
         check(tdo_oe, 1'b1);
      end
   endtask

   // from idle through the data column and back to idle
   task automatic scan_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
      move(8'h01, 3);
      shift(n, din, dout);
      move(8'h01, 2);
      check(tdo_oe, 1'b0);
   endtask

   // from idle: capture, shift, pause and update the instruction
   task automatic load_ir(input instr_t code, input logic dq_old);
      logic [127:0] dout;
      move(8'h03, 4);
      shift(`IR_LEN, {125'h0, code}, dout);
      check(dout[2:0], `IR_CAPTURE_VAL);
      move(8'h00, 1);
      @(negedge core_clk);
      check(dq_float, dq_old);
      @(posedge core_clk);
      move(8'h06, 4);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_id();
      logic [127:0] dout;
      @(negedge core_clk);
      check({tdo, tdo_oe, dq_float}, 3'h0);
      @(posedge core_clk);
      move(8'h00, 1);
      scan_dr(34, 128'h1, dout);
      check(dout[31:0], ID_EXP);
      check(dout[33:32], 2'h1);
      $display("test id done");
   endtask

   task automatic t_bypass();
      logic [127:0] dout;
      load_ir(INS_BYPASS, 1'b0);
      scan_dr(4, 128'h5, dout);
      check(dout[3:0], {3'h5, `BYPASS_CAPTURE_VAL});
      $display("test bypass done");
   endtask

   task automatic t_chain();
      instr_t codes [3] = '{INS_SAMPLE, INS_EXTEST, INS_SAMPLE_FLOAT};
      logic fl [3] = '{1'b0, 1'b1, 1'b1};
      logic prev;
      logic [127:0] base, exp, dout;
      prev = 1'b0;
      base = {32{4'h6}};
      for (int k = 0; k < 3; k++) begin
         pad_in <= base[`BSR_LEN-1:0] ^ {`BSR_LEN{k[0]}};
         load_ir(codes[k], prev);
         @(negedge core_clk);
         check(dq_float, fl[k]);
         @(posedge core_clk);
         exp = '0;
         exp[`BSR_LEN-1:0] = base[`BSR_LEN-1:0] ^ {`BSR_LEN{k[0]}};
         exp[`BSR_INTERNAL_CELL] = fl[k];
         exp[`BSR_LEN] = 1'b1;
         scan_dr(`BSR_LEN + 1, 128'h1, dout);
         check(dout, exp);
         prev = fl[k];
      end
      $display("test chain done");
   endtask

   task automatic t_float();
      logic [127:0] dout;
      host.tms_float <= 1'b1;
      move(8'h00, 5);
      @(negedge core_clk);
      check(dq_float, 1'b0);
      @(posedge core_clk);
      host.tms_float <= 1'b0;
      host.tdi_float <= 1'b1;
      move(8'h00, 1);
      scan_dr(34, 128'h0, dout);
      check(dout[33:0], {2'h3, ID_EXP});
      host.tdi_float <= 1'b0;
      $display("test float done");
   endtask

   // ----------------------------------------------------------------
   // sequence and timeout
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end

   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      t_id();
      t_bypass();
      t_chain();
      t_float();
      finish_test();
   end
endmodule
